/* logic/hcs_cfg.svh */
`ifndef HCS_CFG_SVH
`define HCS_CFG_SVH

// Register byte offsets on the APB
`define HCS_OFF_CSR 12'h000
`define HCS_OFF_SVC 12'h004
`define HCS_OFF_LIM 12'h008

// Field positions of host_ep0_control_status
`define HCS_B_RXRDY 0
`define HCS_B_TXRDY 1
`define HCS_B_STALL 2
`define HCS_B_SETUP 3
`define HCS_B_ERROR 4
`define HCS_B_REQ 5
`define HCS_B_STATUS 6
`define HCS_B_NAKTO 7
`define HCS_B_FLUSH 8
`define HCS_B_TOG 9
`define HCS_B_TWE 10

// Field position of receive_serviced in the service register
`define HCS_B_SVC 0

// Reset values and fixed counts
`define HCS_CSR_RST 16'h0000
`define HCS_LIM_RST 16'h0010
`define HCS_RSVD_ZERO 5'h00
`define HCS_HI_ZERO 16'h0000
`define HCS_TRIES_LAST 2'h2
`define HCS_CNT_ZERO 2'h0
`define HCS_CNT_ONE 2'h1

`endif

/* logic/hcs_pkg.sv */
`default_nettype none

package hcs_pkg;

	// Register word and token kind towards the packet engine
	typedef logic [15:0] hcs_word_t;

	typedef enum logic [1:0]
	{
		HCS_TOK_OUT = 2'h1,
		HCS_TOK_SETUP = 2'h2
	} hcs_tok_e;

endpackage : hcs_pkg

`default_nettype wire

/* logic/hcs_ep0.sv */
// Behaviour
// R1: Toggle write-enable allows a toggle write, then clears itself.
// R2: Reading the toggle bit shows the live endpoint 0 data toggle.
// R3: Toggle write takes effect only with write-enable high, else ignored.
// R4: Flush discards the queued packet, resets FIFO pointer, clears ready flag.
// R5: Flush does nothing unless transmit or receive ready is set.
// R6: Too many consecutive NAKs halt endpoint 0 and set NAK timeout.
// R7: Software clears NAK timeout before endpoint 0 resumes.
// R8: Status-stage bit with transmit-ready or IN-request forces DATA1.
// R9: IN-request issues an IN; cleared when receive ready is set.
// R10: Three unanswered attempts set the error flag and an interrupt.
// R11: Setup bit written with transmit-ready sends SETUP instead of OUT.
// R12: Received STALL sets a sticky flag until software clears it.
// R13: Transmit-ready cleared after the packet is sent, with an interrupt.
// R14: Received data packet sets receive ready and raises an interrupt.
// R15: Receive ready is cleared by writing one to receive-serviced.
// R16: Reserved and write-only bits read as zero; reserved writes ignored.

`default_nettype none

`include "hcs_cfg.svh"

module hcs_ep0
	import hcs_pkg::*;
#(
	parameter int AW = 12,
	parameter int NAKW = 16
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Events from the packet engine, same clock, one-cycle pulses
	input wire logic ev_sent,
	input wire logic ev_data_rx,
	input wire logic ev_stall,
	input wire logic ev_nak,
	input wire logic ev_no_resp,
	input wire logic ev_other_resp,
	// Requests to the packet engine
	output logic out_go,
	output var hcs_tok_e out_token,
	output logic in_go,
	output logic pid_data1,
	output logic fifo_flush,
	output logic ep0_int
);

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// Compares a bus address against one register offset
	function automatic logic hcs_hit(input logic [AW-1:0] addr, input logic [11:0] off);
		hcs_hit = (addr == AW'(off));
	endfunction : hcs_hit

	logic sel_csr;
	logic sel_svc;
	logic sel_lim;
	logic sel_any;
	logic apb_setup;
	logic apb_wr;
	logic wr_csr;
	logic wr_svc;
	logic wr_lim;

	// Decode is shared by the read capture and the write strobes
	assign sel_csr = hcs_hit(paddr, `HCS_OFF_CSR);
	assign sel_svc = hcs_hit(paddr, `HCS_OFF_SVC);
	assign sel_lim = hcs_hit(paddr, `HCS_OFF_LIM);
	assign sel_any = sel_csr | sel_svc | sel_lim;
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pready & pwrite;
	assign wr_csr = apb_wr & sel_csr;
	assign wr_svc = apb_wr & sel_svc;
	assign wr_lim = apb_wr & sel_lim & ~pslverr;

	////////////////////////////////////////////////////////////////////////
	// State

	logic txrdy;
	logic rxrdy;
	logic req;
	logic status;
	logic setup;
	logic toggle;
	logic twe;
	logic [2:0] flag;
	logic [NAKW-1:0] nak_limit;
	logic [NAKW-1:0] nak_cnt;
	logic [1:0] nr_cnt;

	logic stall;
	logic error;
	logic nak_to;
	assign stall = flag[0];
	assign error = flag[1];
	assign nak_to = flag[2];

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	logic flush_do;
	logic nak_hit;
	logic err_hit;
	logic abort;
	logic tx_done;
	logic set_tx;
	logic set_req;
	logic status_force;
	logic setup_force;
	logic tog_load;
	logic next_txrdy;
	logic next_rxrdy;
	logic next_req;
	logic next_status;
	logic next_setup;
	logic next_toggle;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [NAKW-1:0] next_nak_cnt;
	logic [1:0] next_nr_cnt;

	// Flush only acts while a packet is actually queued
	assign flush_do = wr_csr & pwdata[`HCS_B_FLUSH] & (txrdy | rxrdy); // [R4] [R5]

	// Limit of zero disables the NAK watchdog
	assign nak_hit = ev_nak & (nak_limit != '0) & (nak_cnt >= nak_limit); // [R6]
	assign err_hit = ev_no_resp & (nr_cnt == `HCS_TRIES_LAST); // [R10]
	assign abort = err_hit | ev_stall;
	assign tx_done = txrdy & ev_sent;

	// A set only counts when the bit was idle, so a repeat write is harmless
	assign set_tx = wr_csr & pwdata[`HCS_B_TXRDY] & ~txrdy;
	assign set_req = wr_csr & pwdata[`HCS_B_REQ] & ~req;
	assign status_force = wr_csr & pwdata[`HCS_B_STATUS]
		& (pwdata[`HCS_B_TXRDY] | pwdata[`HCS_B_REQ]); // [R8]
	assign setup_force = wr_csr & pwdata[`HCS_B_SETUP] & pwdata[`HCS_B_TXRDY];
	assign tog_load = wr_csr & pwdata[`HCS_B_TWE]; // [R3]

	// Flush wins over a transmit set in the same write
	assign next_txrdy = ~flush_do & ((txrdy & ~ev_sent & ~abort) | set_tx); // [R13] [R4]
	// Incoming packet wins over a clear in the same cycle
	assign next_rxrdy = ev_data_rx
		| (rxrdy & ~flush_do & ~(wr_svc & pwdata[`HCS_B_SVC])); // [R14] [R15] [R4]
	assign next_req = (req & ~ev_data_rx & ~abort) | set_req; // [R9]

	// Stage qualifiers live until the transaction they belong to ends
	assign next_status = wr_csr ? pwdata[`HCS_B_STATUS] : status & (next_txrdy | next_req);
	assign next_setup = wr_csr ? pwdata[`HCS_B_SETUP] : setup & next_txrdy; // [R11]

	// Explicit status force first, then a guarded write, then SETUP's DATA0
	assign next_toggle = status_force ? 1'b1 // [R8]
		: tog_load ? pwdata[`HCS_B_TOG] // [R1] [R3]
		: setup_force ? 1'b0
		: (tx_done | ev_data_rx) ? ~toggle
		: toggle;

	// Sticky flags: hardware sets, software writes zero to clear
	assign flag_set = {nak_hit, err_hit, ev_stall};
	assign flag_clr = {wr_csr & ~pwdata[`HCS_B_NAKTO], wr_csr & ~pwdata[`HCS_B_ERROR],
		wr_csr & ~pwdata[`HCS_B_STALL]};

	// Consecutive NAKs only; any other answer restarts the count, idle cycles hold it
	assign next_nak_cnt = (nak_hit | ev_sent | ev_data_rx | ev_stall | ev_no_resp | ev_other_resp)
		? '0 : ev_nak ? nak_cnt + NAKW'(1) : nak_cnt; // [R6]
	assign next_nr_cnt = (err_hit | ev_sent | ev_data_rx | ev_stall | ev_nak | ev_other_resp)
		? `HCS_CNT_ZERO : ev_no_resp ? nr_cnt + `HCS_CNT_ONE : nr_cnt;

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Handshake bits of the control word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txrdy <= 1'b0;
			rxrdy <= 1'b0;
			req <= 1'b0;
			status <= 1'b0;
			setup <= 1'b0;
		end
		else
		begin
			txrdy <= next_txrdy;
			rxrdy <= next_rxrdy;
			req <= next_req;
			status <= next_status;
			setup <= next_setup;
		end
	end

	// Toggle and its one-cycle write enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			toggle <= 1'b0;
			twe <= 1'b0;
		end
		else
		begin
			toggle <= next_toggle; // [R2]
			twe <= tog_load; // [R1]
		end
	end

	// Sticky flags share one form
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_flag
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					flag[g] <= 1'b0;
				else
					flag[g] <= flag_set[g] | (flag[g] & ~flag_clr[g]); // [R12] [R10] [R6]
			end
		end
	endgenerate

	// Retry and NAK counters, plus the NAK limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nak_cnt <= '0;
			nr_cnt <= `HCS_CNT_ZERO;
			nak_limit <= NAKW'(`HCS_LIM_RST);
		end
		else
		begin
			nak_cnt <= next_nak_cnt;
			nr_cnt <= next_nr_cnt;
			if (wr_lim)
				nak_limit <= pwdata[NAKW-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Engine side outputs, registered from next state

	// Halt holds both directions until software clears the timeout
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_go <= 1'b0;
			in_go <= 1'b0;
			out_token <= HCS_TOK_OUT;
			pid_data1 <= 1'b0;
			fifo_flush <= 1'b0;
			ep0_int <= 1'b0;
		end
		else
		begin
			out_go <= next_txrdy & ~flag_set[2] & ~(nak_to & ~flag_clr[2]); // [R6] [R7]
			in_go <= next_req & ~flag_set[2] & ~(nak_to & ~flag_clr[2]); // [R9]
			out_token <= next_setup ? HCS_TOK_SETUP : HCS_TOK_OUT; // [R11]
			pid_data1 <= next_toggle;
			fifo_flush <= flush_do; // [R4]
			ep0_int <= tx_done | ev_data_rx | err_hit; // [R13] [R14] [R10]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: one access cycle, read data captured in the setup cycle

	hcs_word_t csr_rd;
	hcs_word_t rd_word;

	// Write-only bits and reserved bits read back as zero
	assign csr_rd = {`HCS_RSVD_ZERO, 1'h0, toggle, 1'h0, nak_to, status, req, error,
		setup, stall, txrdy, rxrdy}; // [R16] [R2]
	assign rd_word = sel_csr ? csr_rd : sel_lim ? hcs_word_t'(nak_limit) : `HCS_HI_ZERO;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~sel_any;
			if (apb_setup)
				prdata <= {`HCS_HI_ZERO, rd_word};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rd_csr_setup;
	assign rd_csr_setup = apb_setup & ~pwrite & sel_csr;

	property p_twe_clears;
		tog_load |=> twe ##1 !twe;
	endproperty
	a_twe_clears: assert property (p_twe_clears) else $error("toggle enable stuck"); // [R1]

	property p_toggle_read;
		rd_csr_setup |=> prdata[`HCS_B_TOG] == $past(toggle);
	endproperty
	a_toggle_read: assert property (p_toggle_read) else $error("toggle readback"); // [R2]

	property p_toggle_guard;
		(wr_csr && !pwdata[`HCS_B_TWE] && !status_force && !setup_force && !tx_done
			&& !ev_data_rx) |=> toggle == $past(toggle);
	endproperty
	a_toggle_guard: assert property (p_toggle_guard) else $error("unguarded toggle"); // [R3]

	property p_flush;
		(flush_do && !ev_data_rx) |=> !txrdy && !rxrdy && fifo_flush ##1 !fifo_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("flush did not act"); // [R4]

	property p_flush_idle;
		(wr_csr && pwdata[`HCS_B_FLUSH] && !txrdy && !rxrdy) |=> !fifo_flush;
	endproperty
	a_flush_idle: assert property (p_flush_idle) else $error("flush when idle"); // [R5]

	property p_nak_halt;
		nak_hit |=> nak_to && !out_go && !in_go;
	endproperty
	a_nak_halt: assert property (p_nak_halt) else $error("no NAK halt"); // [R6]

	property p_status_data1;
		status_force |=> toggle && pid_data1;
	endproperty
	a_status_data1: assert property (p_status_data1) else $error("status not DATA1"); // [R8]

	property p_req_clear;
		(req && ev_data_rx) |=> rxrdy && !req;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("IN request stuck"); // [R9]

	property p_error;
		(ev_no_resp && nr_cnt == `HCS_TRIES_LAST) |=> error && ep0_int && !txrdy;
	endproperty
	a_error: assert property (p_error) else $error("no error on third miss"); // [R10]

	property p_setup_tok;
		(setup_force && !flush_do) |=> out_token == HCS_TOK_SETUP;
	endproperty
	a_setup_tok: assert property (p_setup_tok) else $error("SETUP token missing"); // [R11]

	property p_stall_sticky;
		ev_stall |=> stall;
	endproperty
	a_stall_sticky: assert property (p_stall_sticky) else $error("stall lost"); // [R12]

	property p_tx_done;
		tx_done |=> !txrdy && ep0_int;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("transmit not completed"); // [R13]

	property p_rx_int;
		ev_data_rx |=> rxrdy && ep0_int;
	endproperty
	a_rx_int: assert property (p_rx_int) else $error("receive not flagged"); // [R14]

	property p_reserved;
		rd_csr_setup |=> prdata[31:`HCS_B_TWE] == '0 && !prdata[`HCS_B_FLUSH];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits set"); // [R16]

	c_setup_sent: cover property (setup_force ##[1:50] tx_done);
	c_in_data: cover property (set_req ##[1:50] ev_data_rx);
	c_nak_halt: cover property (nak_hit);
	c_flush: cover property (flush_do);

endmodule : hcs_ep0

`default_nettype wire

/* test/hcs_peer.sv */
`default_nettype none

// Attached peripheral: answers each pending transaction after dly cycles
module hcs_peer
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requests from the endpoint logic
	input wire logic out_go,
	input wire logic in_go,
	// Answer kind (0 ack, 1 NAK, 2 silent, 3 STALL) and latency, dly >= 3
	input wire logic [1:0] mode,
	input wire logic [3:0] dly,
	// Handshake events
	output logic ev_sent,
	output logic ev_data_rx,
	output logic ev_stall,
	output logic ev_nak,
	output logic ev_no_resp
);
	logic [3:0] cnt;
	logic fire;

	// One answer per attempt; the count restarts so a dropped request is never answered
	assign fire = (out_go | in_go) && cnt == dly;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 4'h0;
			{ev_sent, ev_data_rx, ev_stall, ev_nak, ev_no_resp} <= 5'h00;
		end
		else
		begin
			cnt <= ((out_go | in_go) && !fire) ? cnt + 4'h1 : 4'h0;
			ev_sent <= fire && mode == 2'h0 && out_go;
			ev_data_rx <= fire && mode == 2'h0 && in_go;
			ev_nak <= fire && mode == 2'h1;
			ev_no_resp <= fire && mode == 2'h2;
			ev_stall <= fire && mode == 2'h3;
		end
	end
endmodule : hcs_peer

`default_nettype wire

/* test/tb.sv */
`default_nettype none

`include "hcs_cfg.svh"

module tb import hcs_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic ev_sent, ev_data_rx, ev_stall, ev_nak, ev_no_resp;
	logic out_go, in_go, pid_data1, fifo_flush, ep0_int, perr, t;
	hcs_tok_e out_token;
	logic [1:0] mode;
	logic [3:0] dly;
	int err_count, total_checks, n_int, n_fl, n_nr, k;

	hcs_ep0 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ev_sent(ev_sent), .ev_data_rx(ev_data_rx), .ev_stall(ev_stall),
		.ev_nak(ev_nak), .ev_no_resp(ev_no_resp), .ev_other_resp(1'b0), .out_go(out_go),
		.out_token(out_token), .in_go(in_go), .pid_data1(pid_data1),
		.fifo_flush(fifo_flush), .ep0_int(ep0_int));
	hcs_peer peer (.pclk(pclk), .presetn(presetn), .out_go(out_go), .in_go(in_go),
		.mode(mode), .dly(dly), .ev_sent(ev_sent), .ev_data_rx(ev_data_rx),
		.ev_stall(ev_stall), .ev_nak(ev_nak), .ev_no_resp(ev_no_resp));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Pulse counters, sampled mid-cycle to stay clear of the launching edge
	always @(negedge pclk)
	begin
		n_int += int'(ep0_int === 1'b1);
		n_fl += int'(fifo_flush === 1'b1);
		n_nr += int'(ev_no_resp === 1'b1);
	end

	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// Expected toggle field on a read: the write enable always reads back as zero
	function automatic logic [1:0] exp_tog(input logic v);
		return {1'b0, v};
	endfunction : exp_tog

	// APB transfer; pready is sampled at rising edges, only the watchdog ends a wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Polls the control word until bit b equals v, with no limit of its own; only the watchdog ends it
	task automatic poll(input int b, input logic v);
		do
		begin
			apb(1'b0, `HCS_OFF_CSR, 32'h0000_0000);
		end
		while (rdat[b] !== v);
	endtask : poll

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	initial
	begin
		#1000000;
		err_count++;
		finish_test();
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{mode, dly} = 6'h03;
		{err_count, total_checks, n_int, n_fl, n_nr} = '0;
		void'($urandom(13));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `HCS_OFF_CSR, 32'h0);
		chk("csr reset", rdat, 32'h0);
		apb(1'b0, `HCS_OFF_LIM, 32'h0);
		chk("limit reset", rdat, 32'h0000_0010);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped err", perr, 32'h1);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_F800);
		apb(1'b0, `HCS_OFF_CSR, 32'h0);
		chk("reserved", rdat, 32'h0);
		// Random toggles loaded, guarded, shown, then moved by an OUT
		for (k = 0; k < 6; k++)
		begin
			t = 1'($urandom % 2);
			dly <= 4'(3 + $urandom % 5);
			apb(1'b1, `HCS_OFF_CSR, {21'h0, 1'b1, t, 9'h000});
			apb(1'b1, `HCS_OFF_CSR, {22'h0, !t, 9'h000});
			apb(1'b0, `HCS_OFF_CSR, 32'h0);
			chk("toggle", rdat[10:9], exp_tog(t));
			chk("pid", pid_data1, t);
			apb(1'b1, `HCS_OFF_CSR, 32'h0000_0002);
			poll(1, 1'b0);
			apb(1'b0, `HCS_OFF_CSR, 32'h0);
			chk("tx done", rdat[1], 1'b0);
			chk("tx toggle", rdat[9], !t);
			chk("tx int", n_int, k + 1);
		end
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_000A);
		@(posedge out_go);
		@(negedge pclk);
		chk("setup token", out_token, HCS_TOK_SETUP);
		chk("setup data0", pid_data1, 1'b0);
		poll(1, 1'b0);
		// Park the toggle at DATA0 so that only the status force can make DATA1
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0400);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0042);
		@(negedge pclk);
		chk("status data1", pid_data1, 1'b1);
		poll(1, 1'b0);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0020);
		poll(0, 1'b1);
		chk("in done", rdat[5:0], 6'h01);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0100);
		apb(1'b0, `HCS_OFF_CSR, 32'h0);
		chk("flush", {rdat[0], 5'(n_fl)}, 6'h01);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0100);
		repeat (2) @(posedge pclk);
		chk("idle flush", n_fl, 1);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0020);
		poll(0, 1'b1);
		apb(1'b1, `HCS_OFF_SVC, 32'h0000_0001);
		apb(1'b0, `HCS_OFF_CSR, 32'h0);
		chk("serviced", rdat[0], 1'b0);
		mode <= 2'h3;
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0020);
		poll(2, 1'b1);
		chk("stall", rdat[2], 1'b1);
		apb(1'b1, `HCS_OFF_CSR, 32'h0);
		mode <= 2'h2;
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0002);
		poll(4, 1'b1);
		repeat (20) @(posedge pclk);
		chk("three tries", n_nr, 3);
		apb(1'b1, `HCS_OFF_CSR, 32'h0);
		mode <= 2'h1;
		apb(1'b1, `HCS_OFF_LIM, 32'h0000_0002);
		apb(1'b1, `HCS_OFF_CSR, 32'h0000_0020);
		poll(7, 1'b1);
		repeat (12) @(posedge pclk);
		chk("nak halt", in_go, 1'b0);
		mode <= 2'h0;
		apb(1'b1, `HCS_OFF_CSR, 32'h0);
		poll(0, 1'b1);
		chk("resume", rdat[7:0], 8'h01);
		finish_test();
	end
endmodule : tb

`default_nettype wire
